// >>> rtl/plcc_consts.svh
// Offsets, field indices, reset values and response codes of the logic cell cluster.
`ifndef PLCC_CONSTS_SVH
`define PLCC_CONSTS_SVH
`define PLCC_CELLS        8
`define PLCC_ADDER_BITS   7
`define PLCC_ADDR_CFG     8'h00
`define PLCC_ADDR_LUT     8'h04
`define PLCC_ADDR_OPND    8'h08
`define PLCC_ADDR_CTL     8'h0c
`define PLCC_ADDR_TRI     8'h10
`define PLCC_ADDR_STAT    8'h14
`define PLCC_SEL_CFG      3'h0
`define PLCC_SEL_LUT      3'h1
`define PLCC_SEL_OPND     3'h2
`define PLCC_SEL_CTL      3'h3
`define PLCC_SEL_TRI      3'h4
`define PLCC_SEL_STAT     3'h5
`define PLCC_SEL_NONE     3'h7
`define PLCC_RESP_OKAY    2'h0
`define PLCC_RESP_SLVERR  2'h2
`define PLCC_G_CLR        0
`define PLCC_G_PRE        1
`define PLCC_G_CKE        2
`define PLCC_G_OE         3
`define PLCC_G_DATA       4
`define PLCC_CFG_RST      8'h00
`define PLCC_LUT_RST      16'h0000
`define PLCC_OPND_RST     24'h000000
`define PLCC_CTL_RST      8'h00
`define PLCC_TRI_RST      8'h00
`endif

// >>> rtl/plcc_pkg.sv
// Types shared by the logic cell cluster.
package plcc_pkg;
    typedef enum logic [1:0] {PLCC_LUT, PLCC_ARITH, PLCC_UPDN, PLCC_CLRCNT} plcc_mode_t;
    typedef struct packed {
        logic       pio_out;
        logic       lut_d4_glob;
        logic       glob_ctl_en;
        logic       aload_en;
        logic       aclr_sel;
        logic       reg_used;
        plcc_mode_t mode;
    } plcc_cfg_t;
    typedef struct packed {
        logic rsvd;
        logic cin0;
        logic ctrl_two;
        logic ctrl_one;
        logic sload;
        logic casc_in;
        logic clk_en;
        logic cnt_en;
    } plcc_ctl_t;
    typedef struct packed {
        logic [7:0] cell_data_in_three;
        logic [7:0] opb;
        logic [7:0] opa;
    } plcc_opnd_t;
endpackage : plcc_pkg

// >>> rtl/plcc_top.sv
// Cluster of eight logic cells with carry chain, counters, tri-state emulation and an AXI4-Lite register port.
// Contract
// RULE1: Cluster groups eight logic cells fed from one local interconnect.
// RULE2: Each cell has a 4-input LUT, one flip-flop, carry and cascade paths.
// RULE3: An n-bit adder uses n+1 cells; last cell carries the final carry out.
// RULE4: Arithmetic mode forms sum of two operand bits and carry-in at cell output.
// RULE5: Cell register is either bypassed or used to accumulate the sum.
// RULE6: Up/down counter has count enable, clock enable, direction and load.
// RULE7: Counter uses next-bit and carry functions plus a two-input load mux.
// RULE8: Counter registers also load asynchronously through clear and preset.
// RULE9: Clearable counter takes synchronous clear on the cascade input.
// RULE10: Load mux output is ANDed with synchronous clear, forcing zero.
// RULE11: Tri-state bus emulation: contention gives low, no driver gives high.
// RULE12: Clear and preset come from data three and both cluster control lines.
// RULE13: With asynchronous load, control one loads data three into the register.
// RULE14: Six dedicated global inputs act as clock enable, clear, preset, enable.
// RULE15: Global inputs can also be read as ordinary data.
// RULE16: Pin cell flip-flop serves as input or output register.
// RULE17: Counter holds its value when disabled and no load or clear is active.
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "plcc_consts.svh"
module plcc_top
    import plcc_pkg::*;
(
    // Clock and reset.
    input  wire logic        CLOCK,
    input  wire logic        RST,
    // AXI4-Lite write channels.
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    // AXI4-Lite read channels.
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    // Dedicated global inputs.
    input  wire logic [5:0]  GLOBAL_IN,
    // Pin I/O cell.
    input  wire logic        PIO_IN,
    output logic             PIO_OUT,
    output logic             PIO_OE,
    // Cluster outputs.
    output logic [7:0]       CLUSTER_OUT,
    output logic             TRI_BUS
);

    function automatic logic [2:0] plcc_dec(input logic [7:0] a);
        logic [7:0] w;
        w = {a[7:2], 2'h0};
        if (w == `PLCC_ADDR_CFG) return `PLCC_SEL_CFG;
        if (w == `PLCC_ADDR_LUT) return `PLCC_SEL_LUT;
        if (w == `PLCC_ADDR_OPND) return `PLCC_SEL_OPND;
        if (w == `PLCC_ADDR_CTL) return `PLCC_SEL_CTL;
        if (w == `PLCC_ADDR_TRI) return `PLCC_SEL_TRI;
        if (w == `PLCC_ADDR_STAT) return `PLCC_SEL_STAT;
        return `PLCC_SEL_NONE;
    endfunction : plcc_dec

    function automatic logic [31:0] plcc_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~m) | (nw & m);
    endfunction : plcc_merge

    // Bus state.
    logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic        aw_pend_q, w_pend_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0]  wstrb_q;
    logic [1:0]  bresp_q, rresp_q;
    // Software registers.
    plcc_cfg_t   cfg_q;
    plcc_ctl_t   ctl_q;
    plcc_opnd_t  opnd_q;
    logic [15:0] lut_q;
    logic [7:0]  tri_en_q;
    // Cluster state.
    logic [7:0]  cell_q, cell_d, out_q;
    logic        tri_q, pio_q, pio_oe_q;
    logic [5:0]  g_s1_q, g_s2_q;
    logic        pin_s1_q, pin_s2_q;

    // Write handshake: address and data are taken in either order.
    wire         aw_hs    = AWVALID & awready_q;
    wire         w_hs     = WVALID & wready_q;
    wire         aw_ok    = aw_pend_q | aw_hs;
    wire         w_ok     = w_pend_q | w_hs;
    wire         do_wr    = aw_ok & w_ok;
    wire         bvalid_d = do_wr | (bvalid_q & ~BREADY);
    wire         aw_pend_d = aw_ok & ~do_wr;
    wire         w_pend_d = w_ok & ~do_wr;
    wire [7:0]   wa       = aw_hs ? AWADDR : awaddr_q;
    wire [31:0]  wd       = w_hs ? WDATA : wdata_q;
    wire [3:0]   ws       = w_hs ? WSTRB : wstrb_q;
    wire [2:0]   wsel     = plcc_dec(wa);
    wire         ar_hs    = ARVALID & arready_q;
    wire         rvalid_d = ar_hs | (rvalid_q & ~RREADY);
    wire [2:0]   rsel     = plcc_dec(ARADDR);

    wire [31:0]  m_cfg  = plcc_merge({24'h0, cfg_q}, wd, ws);
    wire [31:0]  m_lut  = plcc_merge({16'h0, lut_q}, wd, ws);
    wire [31:0]  m_opnd = plcc_merge({8'h0, opnd_q}, wd, ws);
    wire [31:0]  m_ctl  = plcc_merge({24'h0, ctl_q}, wd, ws);
    wire [31:0]  m_tri  = plcc_merge({24'h0, tri_en_q}, wd, ws);

    // Global inputs after synchronisation; the enable bit decides whether they act as controls.
    wire         gen      = cfg_q.glob_ctl_en;
    wire         gclr     = gen & g_s2_q[`PLCC_G_CLR];                            // RULE14
    wire         gpre     = gen & g_s2_q[`PLCC_G_PRE];                            // RULE14
    wire         cke      = ctl_q.clk_en & (~gen | g_s2_q[`PLCC_G_CKE]);          // RULE14
    wire         oe_d     = cfg_q.pio_out & (~gen | g_s2_q[`PLCC_G_OE]);          // RULE14
    wire         d4_glob  = g_s2_q[`PLCC_G_DATA];                                 // RULE15

    // Cluster-wide clear, preset and load decode.
    wire         c1       = ctl_q.ctrl_one;
    wire         c2       = ctl_q.ctrl_two;
    wire         ld_w     = cfg_q.aload_en & c1;                                  // RULE13
    wire         clr_w    = gclr | (cfg_q.aclr_sel ? c2 : (c1 & ~cfg_q.aload_en)); // RULE12
    wire         pre_w    = gpre | (cfg_q.aclr_sel ? (c1 & ~cfg_q.aload_en) : c2); // RULE12
    wire         cnt_mode = (cfg_q.mode == PLCC_UPDN) | (cfg_q.mode == PLCC_CLRCNT);
    wire         sclr     = (cfg_q.mode == PLCC_CLRCNT) & ctl_q.casc_in;          // RULE9
    wire         count_up = (cfg_q.mode == PLCC_CLRCNT) | ctl_q.casc_in;          // RULE6
    wire         sync_ld  = ctl_q.sload | sclr | cke;                             // RULE17

    logic [8:0]  carry;
    logic [7:0]  comb, out_w;
    assign carry[0] = cnt_mode ? ctl_q.cnt_en : ctl_q.cin0;                       // RULE6

    genvar i;
    generate
        for (i = 0; i < `PLCC_CELLS; i++)
        begin : g_cell                                                            // RULE1
            wire       a     = opnd_q.opa[i];
            wire       b     = opnd_q.opb[i];
            wire       d3    = opnd_q.cell_data_in_three[i];
            wire       ci    = carry[i];
            wire       d4    = cfg_q.lut_d4_glob ? d4_glob : ci;                   // RULE15
            wire       lut   = lut_q[{d4, d3, b, a}];                             // RULE2
            wire       sum   = (i < `PLCC_ADDER_BITS) ? (a ^ b ^ ci) : ci;         // RULE3
            wire       nxt   = cell_q[i] ^ ci;                                    // RULE7
            wire       mux   = ctl_q.sload ? d3 : nxt;                            // RULE7
            wire       cnt_d = mux & ~sclr;                                       // RULE10
            wire       cyc   = count_up ? (ci & cell_q[i]) : (ci & ~cell_q[i]);   // RULE7
            assign carry[i + 1] = cnt_mode ? cyc : ((a & b) | (a & ci) | (b & ci)); // RULE2
            assign comb[i] = (cfg_q.mode == PLCC_LUT) ? lut :
                             (cfg_q.mode == PLCC_ARITH) ? sum : nxt;              // RULE4
            assign cell_d[i] = clr_w ? 1'b0 :                                     // RULE8
                               ld_w ? d3 :                                        // RULE13
                               pre_w ? 1'b1 :                                     // RULE8
                               ~cnt_mode ? comb[i] :
                               sync_ld ? cnt_d : cell_q[i];                       // RULE17
            assign out_w[i] = cfg_q.reg_used ? cell_q[i] : comb[i];               // RULE5
        end
    endgenerate

    // Multiplexer emulation of a shared internal bus.
    wire         tri_many = |(tri_en_q & (tri_en_q - 8'h01));
    wire         tri_d    = (tri_en_q == 8'h00) ? 1'b1 :
                            tri_many ? 1'b0 : |(tri_en_q & out_w);               // RULE11
    wire         pio_d    = cfg_q.pio_out ? out_w[0] : pin_s2_q;                  // RULE16

    wire [31:0]  stat_w   = {7'h0, g_s2_q, pio_q, tri_q, carry[8], comb, cell_q};
    wire [31:0]  rd_word  = (rsel == `PLCC_SEL_CFG)  ? {24'h0, cfg_q} :
                            (rsel == `PLCC_SEL_LUT)  ? {16'h0, lut_q} :
                            (rsel == `PLCC_SEL_OPND) ? {8'h0, opnd_q} :
                            (rsel == `PLCC_SEL_CTL)  ? {24'h0, ctl_q} :
                            (rsel == `PLCC_SEL_TRI)  ? {24'h0, tri_en_q} :
                            (rsel == `PLCC_SEL_STAT) ? stat_w : 32'h0;

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            aw_pend_q <= 1'b0;
            w_pend_q  <= 1'b0;
        end
        else
        begin
            awready_q <= ~aw_pend_d & ~bvalid_d;
            wready_q  <= ~w_pend_d & ~bvalid_d;
            bvalid_q  <= bvalid_d;
            arready_q <= ~rvalid_d;
            rvalid_q  <= rvalid_d;
            aw_pend_q <= aw_pend_d;
            w_pend_q  <= w_pend_d;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            awaddr_q <= 8'h00;
            wdata_q  <= 32'h0;
            wstrb_q  <= 4'h0;
            bresp_q  <= `PLCC_RESP_OKAY;
            rdata_q  <= 32'h0;
            rresp_q  <= `PLCC_RESP_OKAY;
        end
        else
        begin
            if (aw_hs) awaddr_q <= AWADDR;
            if (w_hs) wdata_q <= WDATA;
            if (w_hs) wstrb_q <= WSTRB;
            if (do_wr) bresp_q <= (wsel == `PLCC_SEL_NONE) ? `PLCC_RESP_SLVERR : `PLCC_RESP_OKAY;
            if (ar_hs) rdata_q <= rd_word;
            if (ar_hs) rresp_q <= (rsel == `PLCC_SEL_NONE) ? `PLCC_RESP_SLVERR : `PLCC_RESP_OKAY;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            cfg_q    <= plcc_cfg_t'(`PLCC_CFG_RST);
            lut_q    <= `PLCC_LUT_RST;
            opnd_q   <= plcc_opnd_t'(`PLCC_OPND_RST);
            ctl_q    <= plcc_ctl_t'(`PLCC_CTL_RST);
            tri_en_q <= `PLCC_TRI_RST;
        end
        else if (do_wr)
        begin
            if (wsel == `PLCC_SEL_CFG) cfg_q <= plcc_cfg_t'(m_cfg[7:0]);
            if (wsel == `PLCC_SEL_LUT) lut_q <= m_lut[15:0];
            if (wsel == `PLCC_SEL_OPND) opnd_q <= plcc_opnd_t'(m_opnd[23:0]);
            if (wsel == `PLCC_SEL_CTL) ctl_q <= plcc_ctl_t'({1'b0, m_ctl[6:0]});
            if (wsel == `PLCC_SEL_TRI) tri_en_q <= m_tri[7:0];
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            cell_q   <= 8'h00;
            out_q    <= 8'h00;
            tri_q    <= 1'b1;
            pio_q    <= 1'b0;
            pio_oe_q <= 1'b0;
            g_s1_q   <= 6'h00;
            g_s2_q   <= 6'h00;
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
        end
        else
        begin
            cell_q   <= cell_d;
            out_q    <= out_w;
            tri_q    <= tri_d;
            pio_q    <= pio_d;                                                    // RULE16
            pio_oe_q <= oe_d;
            g_s1_q   <= GLOBAL_IN;
            g_s2_q   <= g_s1_q;
            pin_s1_q <= PIO_IN;
            pin_s2_q <= pin_s1_q;
        end
    end

    assign AWREADY     = awready_q;
    assign WREADY      = wready_q;
    assign BVALID      = bvalid_q;
    assign BRESP       = bresp_q;
    assign ARREADY     = arready_q;
    assign RVALID      = rvalid_q;
    assign RDATA       = rdata_q;
    assign RRESP       = rresp_q;
    assign CLUSTER_OUT = out_q;
    assign TRI_BUS     = tri_q;
    assign PIO_OUT     = pio_q;
    assign PIO_OE      = pio_oe_q;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    wire       no_async = ~clr_w & ~ld_w & ~pre_w;
    wire [7:0] add_sum  = {1'b0, opnd_q.opa[6:0]} + {1'b0, opnd_q.opb[6:0]} + {7'h0, ctl_q.cin0};

    property p_tri_float;
        (tri_en_q == 8'h00) |=> TRI_BUS;
    endproperty
    a_tri_float: assert property (p_tri_float) else $error("Undriven bus not high."); // RULE11
    property p_tri_contend;
        tri_many |=> !TRI_BUS;
    endproperty
    a_tri_contend: assert property (p_tri_contend) else $error("Contending bus not low."); // RULE11
    property p_adder;
        (cfg_q.mode == PLCC_ARITH) |-> (comb == add_sum);
    endproperty
    a_adder: assert property (p_adder) else $error("Adder sum or final carry wrong."); // RULE3
    property p_accum;
        (cfg_q.mode == PLCC_ARITH) && cfg_q.reg_used && no_async |=> cell_q == $past(comb) ##1 out_q == $past(cell_q);
    endproperty
    a_accum: assert property (p_accum) else $error("Registered sum not captured."); // RULE5
    property p_count_up;
        (cfg_q.mode == PLCC_UPDN) && ctl_q.cnt_en && cke && ctl_q.casc_in && !ctl_q.sload && no_async
        |=> cell_q == 8'($past(cell_q) + 8'h01);
    endproperty
    a_count_up: assert property (p_count_up) else $error("Up count step wrong."); // RULE7
    property p_sclr;
        (cfg_q.mode == PLCC_CLRCNT) && ctl_q.casc_in && no_async |=> (cell_q == 8'h00);
    endproperty
    a_sclr: assert property (p_sclr) else $error("Synchronous clear did not force zero."); // RULE10
    property p_hold;
        cnt_mode && !(ctl_q.cnt_en && cke) && !ctl_q.sload && !sclr && no_async |=> $stable(cell_q);
    endproperty
    a_hold: assert property (p_hold) else $error("Idle counter changed."); // RULE17
    property p_aload;
        ld_w && !clr_w |=> (cell_q == $past(opnd_q.cell_data_in_three));
    endproperty
    a_aload: assert property (p_aload) else $error("Load of data three failed."); // RULE13
    property p_gclr;
        gclr |=> (cell_q == 8'h00);
    endproperty
    a_gclr: assert property (p_gclr) else $error("Global clear ignored."); // RULE14
    property p_pio_in;
        !cfg_q.pio_out |=> PIO_OUT == $past(pin_s2_q);
    endproperty
    a_pio_in: assert property (p_pio_in) else $error("Input register did not capture pin."); // RULE16

endmodule : plcc_top

// >>> verification/plcc_fabric_model.sv
// Fabric-side model that drives the dedicated global inputs and the pin of the cluster.
`timescale 1ns/1ps
module plcc_fabric_model (
    // Clock.
    input  wire logic       clock,
    // Commands from the bench.
    input  wire logic [5:0] glob_set,
    input  wire logic       pin_set,
    input  wire logic [3:0] cke_pulses,
    input  wire logic       cke_go,
    // Lines into the cluster.
    output logic [5:0]      glob_out,
    output logic            pin_out
);
    logic [3:0] left_q = 4'h0;
    logic       cke_on;
    assign cke_on = (cke_go && cke_pulses != 4'h0) || left_q > 4'h1;
    // The global clock enable is raised for exactly the commanded number of cycles.
    always @(posedge clock)
    begin
        left_q <= cke_go ? cke_pulses : ((left_q != 4'h0) ? left_q - 4'h1 : 4'h0);
        glob_out <= {glob_set[5:3], glob_set[2] | cke_on, glob_set[1:0]};
        pin_out <= pin_set;
    end
endmodule : plcc_fabric_model

// >>> verification/tb.sv
// Self-checking testbench for the logic cell cluster.
`timescale 1ns/1ps
`include "plcc_consts.svh"
module tb;
    import plcc_pkg::*;
    logic        CLOCK = 1'b0;
    logic        RST = 1'b1;
    logic [7:0]  AWADDR = 8'h00;
    logic [7:0]  ARADDR = 8'h00;
    logic [31:0] WDATA = 32'h0;
    logic [3:0]  WSTRB = 4'h0;
    logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, PIO_IN, PIO_OUT, PIO_OE, TRI_BUS;
    logic [1:0]  BRESP, RRESP;
    logic [31:0] RDATA, st;
    logic [7:0]  CLUSTER_OUT;
    logic [5:0]  GLOBAL_IN;
    logic [5:0]  glob_set = 6'h00;
    logic        pin_set = 1'b0, cke_go = 1'b0;
    logic [3:0]  cke_pulses = 4'h0;
    int          failures = 0;
    int          tests_run = 0;
    always #5 CLOCK = ~CLOCK;
    plcc_top DUT (.CLOCK(CLOCK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
        .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
        .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .GLOBAL_IN(GLOBAL_IN), .PIO_IN(PIO_IN),
        .PIO_OUT(PIO_OUT), .PIO_OE(PIO_OE), .CLUSTER_OUT(CLUSTER_OUT), .TRI_BUS(TRI_BUS));
    plcc_fabric_model fabric (.clock(CLOCK), .glob_set(glob_set), .pin_set(pin_set),
        .cke_pulses(cke_pulses), .cke_go(cke_go), .glob_out(GLOBAL_IN), .pin_out(PIO_IN));
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
                      input logic [1:0] er = `PLCC_RESP_OKAY);
        @(posedge CLOCK);
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= s;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do
        begin
            @(posedge CLOCK);
            if (AWREADY)
                AWVALID <= 1'b0;
            if (WREADY)
                WVALID <= 1'b0;
        end
        while (BVALID !== 1'b1);
        BREADY <= 1'b0;
        chk("bresp", 32'(BRESP), 32'(er));
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [1:0] er = `PLCC_RESP_OKAY);
        @(posedge CLOCK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do
        begin
            @(posedge CLOCK);
            if (ARREADY)
                ARVALID <= 1'b0;
        end
        while (RVALID !== 1'b1);
        RREADY <= 1'b0;
        st = RDATA;
        chk("rresp", 32'(RRESP), 32'(er));
    endtask : rd
    task automatic step(input logic [31:0] ctl, input logic [3:0] n, input logic [7:0] exp);
        wr(`PLCC_ADDR_CTL, ctl);
        cke_pulses <= n;
        cke_go <= 1'b1;
        @(posedge CLOCK);
        cke_go <= 1'b0;
        repeat (20) @(posedge CLOCK);
        rd(`PLCC_ADDR_STAT);
        chk("counter", 32'(st[7:0]), 32'(exp));
    endtask : step
    task automatic t_regs;
        logic [7:0] adr [5] = '{`PLCC_ADDR_CFG, `PLCC_ADDR_LUT, `PLCC_ADDR_OPND, `PLCC_ADDR_CTL, `PLCC_ADDR_TRI};
        foreach (adr[i])
        begin
            rd(adr[i]);
            chk("reset value", st, 32'h0);
        end
        rd(8'h18, `PLCC_RESP_SLVERR);
        chk("unmapped read", st, 32'h0);
        wr(8'h1c, 32'hffffffff, 4'hf, `PLCC_RESP_SLVERR);
        wr(`PLCC_ADDR_OPND, 32'h00abcdef, 4'h2);
        rd(`PLCC_ADDR_OPND);
        chk("strobed write", st, 32'h0000cd00);
        $display("test regs done");
    endtask : t_regs
    task automatic t_adder;
        logic [7:0]  s;
        logic        co;
        logic [23:0] v [3] = '{24'h00017f, 24'h002312, 24'h00ff7f};
        logic        c [3] = '{1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 3; i++)
        begin
            s = {1'b0, v[i][6:0]} + {1'b0, v[i][14:8]} + {7'h0, c[i]};
            // The chain runs on through cell 7, whose own operand bits meet the adder's final carry.
            co = (v[i][7] & v[i][15]) | ((v[i][7] | v[i][15]) & s[7]);
            wr(`PLCC_ADDR_CFG, (i == 2) ? 32'h05 : 32'h01);
            wr(`PLCC_ADDR_OPND, {8'h0, v[i]});
            wr(`PLCC_ADDR_CTL, {25'h0, c[i], 6'h0});
            rd(`PLCC_ADDR_STAT);
            chk("adder sum and carry", 32'(st[16:8]), {23'h0, co, s});
            chk("cluster out", 32'(CLUSTER_OUT), 32'(s));
            chk("cell regs", 32'(st[7:0]), 32'(s));
        end
        $display("test adder done");
    endtask : t_adder
    task automatic t_count;
        wr(`PLCC_ADDR_CFG, 32'h26);
        wr(`PLCC_ADDR_OPND, 32'h003c0000);
        step(32'h08, 4'h0, 8'h3c);
        step(32'h07, 4'h0, 8'h3c);
        step(32'h07, 4'h5, 8'h41);
        step(32'h03, 4'h7, 8'h3a);
        step(32'h06, 4'h3, 8'h3a);
        wr(`PLCC_ADDR_CFG, 32'h27);
        step(32'h07, 4'h2, 8'h00);
        step(32'h0c, 4'h0, 8'h00);
        step(32'h08, 4'h0, 8'h3c);
        step(32'h03, 4'h4, 8'h40);
        step(32'h20, 4'h0, 8'hff);
        $display("test counter done");
    endtask : t_count
    task automatic t_async;
        logic [47:0] row [10] = '{48'h00_04_0000_00_00, 48'h00_04_0000_20_ff, 48'h00_04_ffff_10_00,
            48'h00_14_ffff_10_a5, 48'h00_0c_ffff_20_00, 48'h00_0c_0000_10_ff, 48'h01_24_ffff_00_00,
            48'h02_24_0000_00_ff, 48'h10_44_ff00_00_ff, 48'h00_44_ff00_00_00};
        wr(`PLCC_ADDR_OPND, 32'h00a50000);
        foreach (row[i])
        begin
            glob_set <= row[i][45:40];
            wr(`PLCC_ADDR_CFG, {24'h0, row[i][39:32]});
            wr(`PLCC_ADDR_LUT, {16'h0, row[i][31:16]});
            wr(`PLCC_ADDR_CTL, {24'h0, row[i][15:8]});
            rd(`PLCC_ADDR_STAT);
            chk("cell regs", 32'(st[7:0]), {24'h0, row[i][7:0]});
            chk("globals seen", 32'(st[24:19]), {26'h0, row[i][45:40]});
        end
        glob_set <= 6'h00;
        $display("test clear preset load done");
    endtask : t_async
    task automatic t_tri;
        logic exp;
        wr(`PLCC_ADDR_CTL, 32'h0);
        wr(`PLCC_ADDR_CFG, 32'h0);
        wr(`PLCC_ADDR_LUT, 32'haaaa);
        wr(`PLCC_ADDR_OPND, 32'h05);
        for (int e = 0; e < 8; e++)
        begin
            exp = (e == 0) ? 1'b1 : (($countones(e) > 1) ? 1'b0 : |(3'(e) & 3'h5));
            wr(`PLCC_ADDR_TRI, 32'(e));
            rd(`PLCC_ADDR_STAT);
            chk("tri status", 32'(st[17]), 32'(exp));
            chk("tri bus", 32'(TRI_BUS), 32'(exp));
        end
        $display("test tri bus done");
    endtask : t_tri
    task automatic t_pin;
        for (int p = 1; p >= 0; p--)
        begin
            pin_set <= 1'(p);
            repeat (6) @(posedge CLOCK);
            rd(`PLCC_ADDR_STAT);
            chk("pin input reg", 32'(st[18]), 32'(p));
        end
        wr(`PLCC_ADDR_CFG, 32'h80);
        repeat (4) @(posedge CLOCK);
        chk("pin output reg", 32'(PIO_OUT), 32'h1);
        chk("pin enable", 32'(PIO_OE), 32'h1);
        wr(`PLCC_ADDR_CFG, 32'ha0);
        repeat (4) @(posedge CLOCK);
        chk("pin enable gated", 32'(PIO_OE), 32'h0);
        glob_set <= 6'h08;
        repeat (6) @(posedge CLOCK);
        chk("pin enable global", 32'(PIO_OE), 32'h1);
        $display("test pin cell done");
    endtask : t_pin
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (6) @(posedge CLOCK);
        RST <= 1'b0;
        repeat (2) @(posedge CLOCK);
        t_regs;
        t_adder;
        t_count;
        t_async;
        t_tri;
        t_pin;
        conclude;
    end
    initial
    begin
        repeat (20000) @(posedge CLOCK);
        failures++;
        $display("watchdog expired");
        conclude;
    end
endmodule : tb
